// file: ssf_defines.vh
// constants for the serial status flag block
// assumes inclusion by bare name from the design file
`ifndef SSF_DEFINES_VH
`define SSF_DEFINES_VH
`define SSF_ADDR_STATUS 4'h0
`define SSF_ADDR_CONTROL 4'h4
`define SSF_ADDR_IRQ_STATUS 4'h8
`define SSF_ADDR_IRQ_MASK 4'hC
`define SSF_BIT_TDE 7
`define SSF_BIT_RDF 6
`define SSF_BIT_OVR 5
`define SSF_BIT_FER 4
`define SSF_BIT_PER 3
`define SSF_BIT_TX_END_FLAG 2
`define SSF_BIT_MPR 1
`define SSF_BIT_MPT 0
`define SSF_BIT_TXEN 0
`define SSF_BIT_RXEN 1
`define SSF_BIT_MULTIPROC_INT_ENABLE 2
`define SSF_STATUS_RESET 8'h84
`define SSF_CONTROL_RESET 3'h0
`define SSF_RESP_OKAY 2'b00
`define SSF_RESP_SLVERR 2'b10
`define SSF_IRQ_W 6
`endif

// file: ssf_dp_model.sv
// stand-in for the serial shift paths that strobe status events
// assumes the shared aclk; every strobe lasts exactly one cycle
`timescale 1ns/1ps
module ssf_dp_model (
  input wire aclk,
  output reg tx_load,
  output reg tx_last_bit,
  output reg tx_data_write,
  output reg rx_buffer_read,
  output reg rx_done,
  output reg rx_mp_bit,
  output reg rx_overrun,
  output reg rx_framing,
  output reg rx_parity
);
  initial {tx_load, tx_last_bit, tx_data_write, rx_buffer_read, rx_done, rx_mp_bit, rx_overrun, rx_framing, rx_parity} = 0;
  // qualifiers flip after the strobe so a stale level never looks valid
  task pulse(input [8:0] v);
    begin
      @(posedge aclk);
      {tx_load, tx_last_bit, tx_data_write, rx_buffer_read, rx_done, rx_mp_bit, rx_overrun, rx_framing, rx_parity} <= v;
      @(posedge aclk);
      {tx_load, tx_last_bit, tx_data_write, rx_buffer_read, rx_done, rx_mp_bit, rx_overrun, rx_framing, rx_parity} <= {5'h0, ~v[3:0]};
    end
  endtask
endmodule

// file: ssf_status.v
// serial status flags with an axi4-lite slave, control bits and interrupt logic
// assumes datapath strobes are single-cycle and come from logic on aclk
//
// Overview of operation
// - writing one to tx empty, rx full, overrun, framing, parity flags does nothing
// - tx empty sets while transmitter disabled or when buffer moves to shift register
// - tx empty clears on zero write after it was read as one
// - writing transmit data clears tx empty
// - rx full sets when a good byte moves into the receive buffer
// - rx full clears on read-one then write-zero, or on receive buffer read
// - overrun sets on overrun; cleared only by read-one then write-zero
// - framing flag sets on framing error; read-one then write-zero clears it
// - parity flag sets on parity error; read-one then write-zero clears it
// - tx end is read-only and set while transmitter disabled
// - tx end sets at last bit if tx empty; clears with tx empty clear or data write
// - rx multiproc bit captures the multiprocessor bit of each received character
// - rx multiproc bit holds while receiver disabled
// - tx multiproc bit is read/write and feeds each transmitted character
// - with multiproc enable, mp-zero chars set only the parity flag; mp-one char clears enable
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "ssf_defines.vh"
module ssf_status (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire tx_load,
  input wire tx_last_bit,
  input wire tx_data_write,
  input wire rx_done,
  input wire rx_mp_bit,
  input wire rx_overrun,
  input wire rx_framing,
  input wire rx_parity,
  input wire rx_buffer_read,
  output reg tx_enable_bit,
  output reg rx_enable_bit,
  output reg tx_multiproc_bit,
  output reg irq
);
  reg tx_buffer_empty;
  reg rx_buffer_full;
  reg overrun_flag;
  reg framing_error_flag;
  reg parity_error_flag;
  reg tx_end_flag;
  reg rx_multiproc_bit;
  reg multiproc_int_enable;
  // armed bits remember a read returning one since the flag last set
  reg [4:0] armed;
  reg [`SSF_IRQ_W-1:0] irq_status;
  reg [`SSF_IRQ_W-1:0] irq_mask;
  reg aw_held;
  reg w_held;
  reg [3:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire [7:0] status_word;
  wire [4:0] flag_vec;
  wire [4:0] set_vec;
  wire [4:0] zero_wr;
  wire [4:0] next_flag;
  wire do_write;
  wire do_read;
  wire wr_status;
  wire rd_status;
  wire rx_accept;
  wire rx_skip;
  wire tde_cleared;
  wire [`SSF_IRQ_W-1:0] irq_event;

  assign status_word = {tx_buffer_empty, rx_buffer_full, overrun_flag, framing_error_flag,
                        parity_error_flag, tx_end_flag, rx_multiproc_bit, tx_multiproc_bit};
  assign flag_vec = status_word[7:3];
  // write fires once both address and data are held and no response is pending
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign wr_status = do_write && (aw_addr == `SSF_ADDR_STATUS) && w_strb[0];
  assign rd_status = do_read && (s_axi_araddr == `SSF_ADDR_STATUS);

  // mp-zero characters set no rx full, overrun or framing flag while the enable is set
  assign rx_skip = multiproc_int_enable && !rx_mp_bit;
  assign rx_accept = rx_done && !rx_skip;

  // hardware set conditions per flag, msb is tx empty
  assign set_vec[4] = !tx_enable_bit || tx_load;
  assign set_vec[3] = rx_accept && !rx_overrun && !rx_framing && !rx_parity;
  assign set_vec[2] = rx_accept && rx_overrun;
  assign set_vec[1] = rx_accept && rx_framing;
  assign set_vec[0] = rx_done && rx_parity;

  // per-flag set/clear, zero writes on an armed flag clear, as do data write and buffer read; ones ignored
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_flag
      assign zero_wr[gi] = wr_status && !w_data[3 + gi] && armed[gi];
      assign next_flag[gi] = set_vec[gi] ? 1'b1 :
        ((zero_wr[gi] || (gi == 4 && tx_data_write) || (gi == 3 && rx_buffer_read)) ? 1'b0 :
        flag_vec[gi]);
    end
  endgenerate
  assign tde_cleared = zero_wr[4] || tx_data_write;

  assign irq_event = {set_vec[4] && !tx_buffer_empty, set_vec[3:0],
                      (!tx_enable_bit || (tx_last_bit && tx_buffer_empty)) && !tx_end_flag};

  // status flags and arming
  always @(posedge aclk) begin
    if (!aresetn) begin
      tx_buffer_empty <= 1'b1;
      rx_buffer_full <= 1'b0;
      overrun_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      tx_end_flag <= 1'b1;
      rx_multiproc_bit <= 1'b0;
      armed <= 5'h0;
    end else begin
      {tx_buffer_empty, rx_buffer_full, overrun_flag, framing_error_flag, parity_error_flag} <= next_flag;
      // a fresh set disarms so a stale read cannot clear a new event
      armed <= (armed | (rd_status ? flag_vec : 5'h0)) & ~set_vec & next_flag;
      if (!tx_enable_bit || (tx_last_bit && tx_buffer_empty)) begin
        tx_end_flag <= 1'b1;
      end else if (tde_cleared) begin
        tx_end_flag <= 1'b0;
      end
      // receiver disabled freezes the captured bit
      if (rx_done && rx_enable_bit) begin
        rx_multiproc_bit <= rx_mp_bit;
      end
    end
  end

  // control bits and interrupt registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      {multiproc_int_enable, rx_enable_bit, tx_enable_bit} <= `SSF_CONTROL_RESET;
      tx_multiproc_bit <= 1'b0;
      irq_status <= {`SSF_IRQ_W{1'b0}};
      irq_mask <= {`SSF_IRQ_W{1'b0}};
      irq <= 1'b0;
    end else begin
      if (wr_status) begin
        tx_multiproc_bit <= w_data[`SSF_BIT_MPT];
      end
      if (do_write && aw_addr == `SSF_ADDR_CONTROL && w_strb[0]) begin
        tx_enable_bit <= w_data[`SSF_BIT_TXEN];
        rx_enable_bit <= w_data[`SSF_BIT_RXEN];
      end
      if (rx_done && multiproc_int_enable && rx_mp_bit) begin
        multiproc_int_enable <= 1'b0;
      end else if (do_write && aw_addr == `SSF_ADDR_CONTROL && w_strb[0]) begin
        multiproc_int_enable <= w_data[`SSF_BIT_MULTIPROC_INT_ENABLE];
      end
      if (do_write && aw_addr == `SSF_ADDR_IRQ_MASK && w_strb[0]) begin
        irq_mask <= w_data[`SSF_IRQ_W-1:0];
      end
      // set wins over write-one-to-clear
      if (do_write && aw_addr == `SSF_ADDR_IRQ_STATUS && w_strb[0]) begin
        irq_status <= (irq_status & ~w_data[`SSF_IRQ_W-1:0]) | irq_event;
      end else begin
        irq_status <= irq_status | irq_event;
      end
      irq <= |(irq_status & irq_mask);
    end
  end

  // axi4-lite write channels, address and data captured independently
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SSF_RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `SSF_ADDR_STATUS || aw_addr == `SSF_ADDR_CONTROL ||
            aw_addr == `SSF_ADDR_IRQ_STATUS || aw_addr == `SSF_ADDR_IRQ_MASK) begin
          s_axi_bresp <= `SSF_RESP_OKAY;
        end else begin
          s_axi_bresp <= `SSF_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // axi4-lite read channel, one outstanding read
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SSF_RESP_OKAY;
    end else begin
      if (do_read) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SSF_RESP_OKAY;
        if (s_axi_araddr == `SSF_ADDR_STATUS) begin
          s_axi_rdata <= {24'h00_0000, status_word};
        end else if (s_axi_araddr == `SSF_ADDR_CONTROL) begin
          s_axi_rdata <= {29'h0000_0000, multiproc_int_enable, rx_enable_bit, tx_enable_bit};
        end else if (s_axi_araddr == `SSF_ADDR_IRQ_STATUS) begin
          s_axi_rdata <= {26'h000_0000, irq_status};
        end else if (s_axi_araddr == `SSF_ADDR_IRQ_MASK) begin
          s_axi_rdata <= {26'h000_0000, irq_mask};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `SSF_RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// file: ssf_status_sva.sv
// port checker for the serial status block
// assumes a bind from the testbench top and the single aclk domain
`timescale 1ns/1ps
`include "ssf_defines.vh"
module ssf_status_sva (
  input wire aclk,
  input wire aresetn,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire tx_enable_bit,
  input wire rx_enable_bit,
  input wire tx_multiproc_bit
);
  reg [3:0] wa;
  reg [3:0] ra;
  reg [7:0] wd;
  reg ws;
  // keep what was taken, since the effect lands cycles later
  always @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[7:0];
    if (s_axi_wvalid && s_axi_wready) ws <= s_axi_wstrb[0];
    if (s_axi_arvalid && s_axi_arready) ra <= s_axi_araddr;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  mpt_write_a:
    assert property ($rose(s_axi_bvalid) && wa == `SSF_ADDR_STATUS && ws |-> tx_multiproc_bit == wd[0]) else $error("mp bit write lost");
  mpt_hold_a:
    assert property (!$rose(s_axi_bvalid) |-> $stable(tx_multiproc_bit)) else $error("mp bit moved");
  ctl_write_a:
    assert property ($rose(s_axi_bvalid) && wa == `SSF_ADDR_CONTROL && ws |-> {rx_enable_bit, tx_enable_bit} == wd[1:0])
      else $error("enable write lost");
  ctl_hold_a:
    assert property (!$rose(s_axi_bvalid) |-> $stable({rx_enable_bit, tx_enable_bit})) else $error("enable moved");
  tx_off_flags_a:
    assert property (s_axi_rvalid && ra == `SSF_ADDR_STATUS && !tx_enable_bit && !$past(tx_enable_bit) && !$past(tx_enable_bit, 2)
      |-> s_axi_rdata[7] && s_axi_rdata[2]) else $error("tx flags clear while disabled");
  read_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready) else $error("late read answer");
  read_release_a:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready) else $error("read not released");
  write_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("late write answer");
endmodule

// file: tb.sv
// self-checking bench for the serial status flags
// assumes the design and checker files compile first
`timescale 1ns/1ps
`include "ssf_defines.vh"
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin error_cnt++; $display("Error %s expected %h seen %h", n, e, s); end end
module tb;
  reg aclk = 0;
  reg aresetn = 0;
  reg [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hF;
  reg [31:0] s_axi_wdata = 0;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire tx_load, tx_last_bit, tx_data_write, rx_buffer_read, rx_done, rx_mp_bit, rx_overrun, rx_framing, rx_parity;
  wire tx_enable_bit, rx_enable_bit, tx_multiproc_bit;
  int error_cnt = 0;
  int tests_run = 0;
  reg [7:0] r;
  reg [1:0] br, rr;
  ssf_status ssf_status_i (.*);
  ssf_dp_model ssf_dp_model_i (.*);
  always #25 aclk = ~aclk;
  task end_of_test;
    begin
      $display("tests_run %0d error_cnt %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  // address and data offered together, each dropped once taken
  task wr(input [3:0] a, input [7:0] d);
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      fork
        begin @(posedge aclk iff s_axi_awready); s_axi_awvalid <= 0; end
        begin @(posedge aclk iff s_axi_wready); s_axi_wvalid <= 0; end
      join
      @(posedge aclk iff s_axi_bvalid);
      br = s_axi_bresp;
      s_axi_bready <= 0;
    end
  endtask
  task rd(input [3:0] a, output [7:0] d);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      @(posedge aclk iff s_axi_arready);
      s_axi_arvalid <= 0;
      @(posedge aclk iff s_axi_rvalid);
      d = s_axi_rdata[7:0];
      rr = s_axi_rresp;
      s_axi_rready <= 0;
    end
  endtask
  task rc(input [3:0] a, input [7:0] e);
    begin
      rd(a, r);
      `CHK("register", e, r)
    end
  endtask
  task ev(input [8:0] v);
    ssf_dp_model_i.pulse(v);
  endtask
  // watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #(50 * 5000);
    error_cnt++;
    end_of_test;
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1;
    rc(`SSF_ADDR_STATUS, 8'h84);
    rc(`SSF_ADDR_CONTROL, 8'h00);
    wr(`SSF_ADDR_STATUS, 8'hFF);
    rc(`SSF_ADDR_STATUS, 8'h85);
    `CHK("mp out", 1'b1, tx_multiproc_bit)
    wr(`SSF_ADDR_CONTROL, 8'h01);
    ev(9'h040);
    rc(`SSF_ADDR_STATUS, 8'h01);
    ev(9'h100);
    rc(`SSF_ADDR_STATUS, 8'h81);
    ev(9'h080);
    rc(`SSF_ADDR_STATUS, 8'h85);
    wr(`SSF_ADDR_STATUS, 8'h01);
    rc(`SSF_ADDR_STATUS, 8'h01);
    ev(9'h100);
    wr(`SSF_ADDR_STATUS, 8'h01);
    rc(`SSF_ADDR_STATUS, 8'h81);
    wr(`SSF_ADDR_CONTROL, 8'h03);
    ev(9'h018);
    rc(`SSF_ADDR_STATUS, 8'hC3);
    ev(9'h020);
    rc(`SSF_ADDR_STATUS, 8'h83);
    ev(9'h01F);
    rc(`SSF_ADDR_STATUS, 8'hBB);
    wr(`SSF_ADDR_STATUS, 8'h81);
    rc(`SSF_ADDR_STATUS, 8'h83);
    wr(`SSF_ADDR_CONTROL, 8'h01);
    ev(9'h010);
    rd(`SSF_ADDR_STATUS, r);
    `CHK("mp in", 1'b1, r[1])
    ev(9'h020);
    wr(`SSF_ADDR_CONTROL, 8'h07);
    ev(9'h010);
    rd(`SSF_ADDR_STATUS, r);
    `CHK("rx full", 1'b0, r[6])
    rc(`SSF_ADDR_CONTROL, 8'h07);
    ev(9'h018);
    rc(`SSF_ADDR_STATUS, 8'hC3);
    rc(`SSF_ADDR_CONTROL, 8'h03);
    // hardware set lands on the clearing write's effect edge
    fork
      wr(`SSF_ADDR_STATUS, 8'h81);
      begin @(posedge aclk); ev(9'h018); end
    join
    rc(`SSF_ADDR_STATUS, 8'hC3);
    wr(`SSF_ADDR_STATUS, 8'h81);
    rc(`SSF_ADDR_STATUS, 8'h83);
    `CHK("irq", 1'b0, irq)
    rc(`SSF_ADDR_IRQ_STATUS, 8'h3F);
    wr(`SSF_ADDR_IRQ_MASK, 8'h10);
    repeat (2) @(posedge aclk);
    `CHK("irq", 1'b1, irq)
    wr(`SSF_ADDR_IRQ_STATUS, 8'h3F);
    repeat (2) @(posedge aclk);
    `CHK("irq", 1'b0, irq)
    rc(`SSF_ADDR_IRQ_STATUS, 8'h00);
    // low strobe bit off means the write must leave the status byte alone
    @(posedge aclk);
    s_axi_wstrb <= 4'h0;
    wr(`SSF_ADDR_STATUS, 8'h00);
    `CHK("bresp", `SSF_RESP_OKAY, br)
    @(posedge aclk);
    s_axi_wstrb <= 4'hF;
    rc(`SSF_ADDR_STATUS, 8'h83);
    `CHK("rresp", `SSF_RESP_OKAY, rr)
    // unmapped offset answers with an error and reads zero
    wr(4'h2, 8'h00);
    `CHK("bresp", `SSF_RESP_SLVERR, br)
    rc(4'h2, 8'h00);
    `CHK("rresp", `SSF_RESP_SLVERR, rr)
    end_of_test;
  end
endmodule
bind ssf_status ssf_status_sva ssf_status_sva_i (.*);
